// ### rtl/cpm_pkg.sv
`default_nettype none
package cpm_pkg;
    // ==========================================================
    // sizes
    localparam int unsigned SYS_PRE_W = 13;
    localparam int unsigned WCH_PRE_W = 5;
    localparam int unsigned NUM_MOD = 8;
    localparam int unsigned NUM_SEL = 4;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned ADDR_W = 8;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_SYSCTL1 = 8'h00;
    localparam logic [7:0] OFS_SYSCTL2 = 8'h04;
    localparam logic [7:0] OFS_TBMODE = 8'h08;
    localparam logic [7:0] OFS_MODSTBY = 8'h0c;
    localparam logic [7:0] OFS_TAPSEL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ==========================================================
    // field positions
    localparam int unsigned POS_SOFTWARE_STANDBY_SELECT = 7;
    localparam int unsigned POS_MA = 4;
    localparam int unsigned POS_LSON = 3;
    localparam int unsigned POS_SA = 0;
    localparam int unsigned POS_TB_SEL = 4;
    localparam int unsigned POS_TB_RST_HI = 3;
    localparam int unsigned POS_TB_RST_LO = 2;

    // ==========================================================
    // encodings of the system clock divider select field
    localparam logic [2:0] MA_OSC = 3'h0;
    localparam logic [2:0] MA_DIV8 = 3'h4;
    localparam logic [2:0] MA_DIV16 = 3'h5;
    localparam logic [2:0] MA_DIV32 = 3'h6;
    localparam logic [2:0] MA_DIV64 = 3'h7;
    // terminal counts of the oscillator divider
    localparam logic [5:0] TERM_OSC = 6'h00;
    localparam logic [5:0] TERM_DIV8 = 6'h07;
    localparam logic [5:0] TERM_DIV16 = 6'h0f;
    localparam logic [5:0] TERM_DIV32 = 6'h1f;
    localparam logic [5:0] TERM_DIV64 = 6'h3f;

    // subclock select: 0 -> w/2, 1 -> w/4, 2 and 3 -> w/8
    localparam logic [1:0] SA_DIV2 = 2'h0;
    localparam logic [1:0] SA_DIV4 = 2'h1;
    localparam logic [2:0] SA_MASK_DIV2 = 3'h6;
    localparam logic [2:0] SA_MASK_DIV4 = 3'h4;
    localparam logic [2:0] SA_MASK_DIV8 = 3'h0;
    // watch divider count on which the watch prescaler steps, once every 4 watch ticks
    localparam logic [1:0] W4_LAST = 2'h3;

    // ==========================================================
    // reset values
    localparam logic [SYS_PRE_W-1:0] SYS_PRE_RST = 13'h0000;
    localparam logic [WCH_PRE_W-1:0] WCH_PRE_RST = 5'h00;
    localparam logic [SEL_W-1:0] TAPSEL_RST = 4'h0;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        CPM_ACTIVE,
        CPM_SLEEP,
        CPM_SUBACTIVE,
        CPM_SUBSLEEP,
        CPM_STANDBY
    } cpm_mode_e;

    typedef struct packed {
        logic software_standby_select;
        logic [2:0] ma;
        logic lson;
        logic [1:0] sa;
        logic tb_sel;
        logic [NUM_MOD-1:0] mstop;
    } cpm_ctrl_s;

    localparam cpm_ctrl_s CTRL_RST = '0;
endpackage
`default_nettype wire

// ### rtl/cpm_clock_ctrl.sv
// Chosen here: the register offsets and register access over APB.
`default_nettype none
module cpm_clock_ctrl
    import cpm_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // watch clock pin and cpu power requests
    input wire logic watch_clk_pin,
    input wire logic sleep_req,
    input wire logic wake_req,
    // clock enables to cpu and peripherals
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic [NUM_MOD-1:0] module_clk_en,
    output logic time_base_tick,
    // prescaler taps
    output logic [SYS_PRE_W-1:0] sys_taps,
    output logic [WCH_PRE_W-1:0] watch_taps,
    output logic [NUM_SEL-1:0] periph_tick,
    // current power mode
    output logic [2:0] power_mode
);

    // ==========================================================
    // state
    cpm_ctrl_s ctrl_q;
    cpm_mode_e mode_q;
    logic [SEL_W-1:0] tap_sel_q [NUM_SEL];
    logic [SYS_PRE_W-1:0] pres_s_q;
    logic [WCH_PRE_W-1:0] pres_w_q;
    logic [5:0] div_q;
    logic [2:0] wdiv_q;
    logic w_sync1_q, w_sync2_q, w_prev_q;
    logic [NUM_SEL-1:0] periph_tick_q;
    logic [31:0] prdata_q;
    logic slverr_q;

    logic wr_en, setup_ph, tb_clr;
    logic sys_run, sub_run, sys_tick, w_tick, w4_tick, sub_tick;
    logic [5:0] div_term;
    logic [2:0] sa_mask;

    // ==========================================================
    // apb slave: zero wait, read data captured in setup phase
    assign pready = 1'b1;
    assign setup_ph = psel & ~penable;
    assign wr_en = psel & penable & pwrite & ~slverr_q;
    assign prdata = prdata_q;
    assign pslverr = slverr_q;

    // control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_en) begin
            if (paddr == OFS_SYSCTL1) begin
                ctrl_q.software_standby_select <= pwdata[POS_SOFTWARE_STANDBY_SELECT];
            end else if (paddr == OFS_SYSCTL2) begin
                ctrl_q.ma <= pwdata[POS_MA +: 3];
                ctrl_q.lson <= pwdata[POS_LSON];
                ctrl_q.sa <= pwdata[POS_SA +: 2];
            end else if (paddr == OFS_TBMODE) begin
                ctrl_q.tb_sel <= pwdata[POS_TB_SEL];
            end else if (paddr == OFS_MODSTBY) begin
                ctrl_q.mstop <= pwdata[NUM_MOD-1:0];
            end
        end
    end

    // per-peripheral tap selects, one nibble each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                tap_sel_q[i] <= TAPSEL_RST;
            end
        end else if (wr_en && paddr == OFS_TAPSEL) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                tap_sel_q[i] <= pwdata[i*SEL_W +: SEL_W];
            end
        end
    end

    // both reset bits set in one write give a one-cycle clear
    // watch prescaler clear
    assign tb_clr = wr_en && paddr == OFS_TBMODE
        && pwdata[POS_TB_RST_HI] && pwdata[POS_TB_RST_LO];

    // read mux; prescaler counts are deliberately absent
    // no counter access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            slverr_q <= 1'b0;
        end else if (setup_ph) begin
            slverr_q <= 1'b0;
            prdata_q <= '0;
            if (paddr == OFS_SYSCTL1) begin
                prdata_q[POS_SOFTWARE_STANDBY_SELECT] <= ctrl_q.software_standby_select;
            end else if (paddr == OFS_SYSCTL2) begin
                prdata_q[POS_MA +: 3] <= ctrl_q.ma;
                prdata_q[POS_LSON] <= ctrl_q.lson;
                prdata_q[POS_SA +: 2] <= ctrl_q.sa;
            end else if (paddr == OFS_TBMODE) begin
                prdata_q[POS_TB_SEL] <= ctrl_q.tb_sel;
            end else if (paddr == OFS_MODSTBY) begin
                prdata_q[NUM_MOD-1:0] <= ctrl_q.mstop;
            end else if (paddr == OFS_TAPSEL) begin
                for (int i = 0; i < NUM_SEL; i++) begin
                    prdata_q[i*SEL_W +: SEL_W] <= tap_sel_q[i];
                end
            end else if (paddr == OFS_STATUS) begin
                prdata_q[2:0] <= mode_q;
            end else begin
                slverr_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // power mode sequencer; wake returns to the clock lson picks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= CPM_ACTIVE;
        end else begin
            case (mode_q)
                CPM_ACTIVE, CPM_SUBACTIVE: begin
                    if (sleep_req && ctrl_q.software_standby_select) begin
                        mode_q <= CPM_STANDBY;
                    end else if (sleep_req) begin
                        mode_q <= (mode_q == CPM_ACTIVE) ?
                            CPM_SLEEP : CPM_SUBSLEEP;
                    end
                end
                CPM_SLEEP, CPM_SUBSLEEP, CPM_STANDBY: begin
                    if (wake_req) begin
                        mode_q <= ctrl_q.lson ? CPM_SUBACTIVE : CPM_ACTIVE;
                    end
                end
                default: begin
                    mode_q <= CPM_ACTIVE;
                end
            endcase
        end
    end
    assign power_mode = mode_q;

    // ==========================================================
    // system clock: oscillator divided by the select field
    // generator stops outside active and sleep
    assign sys_run = mode_q == CPM_ACTIVE || mode_q == CPM_SLEEP;
    assign sub_run = mode_q == CPM_SUBACTIVE || mode_q == CPM_SUBSLEEP;

    always_comb begin
        case (ctrl_q.ma)
            MA_DIV8: div_term = TERM_DIV8;
            MA_DIV16: div_term = TERM_DIV16;
            MA_DIV32: div_term = TERM_DIV32;
            MA_DIV64: div_term = TERM_DIV64;
            default: div_term = TERM_OSC; // reserved codes run undivided
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (!sys_run || div_q >= div_term) begin
            div_q <= '0; // >= so a shrinking ratio cannot overshoot
        end else begin
            div_q <= div_q + 6'h01;
        end
    end
    assign sys_tick = sys_run && div_q >= div_term;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pres_s_q <= SYS_PRE_RST;
        end else if (!sys_run) begin
            pres_s_q <= SYS_PRE_RST;
        end else if (sys_tick) begin
            pres_s_q <= pres_s_q + 13'h0001;
        end
    end
    // bit k toggles at system clock / 2^(k+1)
    assign sys_taps = pres_s_q;

    for (genvar g = 0; g < NUM_SEL; g++) begin : g_tap
        logic [SYS_PRE_W-1:0] low_mask;
        assign low_mask = (13'h0002 << tap_sel_q[g]) - 13'h0001;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                periph_tick_q[g] <= 1'b0;
            end else begin
                periph_tick_q[g] <= sys_tick && &(pres_s_q | ~low_mask);
            end
        end
    end
    assign periph_tick = periph_tick_q;

    // ==========================================================
    // watch clock pin: two-stage synchroniser, then edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_sync1_q <= 1'b0;
            w_sync2_q <= 1'b0;
            w_prev_q <= 1'b0;
        end else begin
            w_sync1_q <= watch_clk_pin;
            w_sync2_q <= w_sync1_q;
            w_prev_q <= w_sync2_q;
        end
    end
    assign w_tick = w_sync2_q & ~w_prev_q;

    // free-running watch divider feeds /4 and the subclock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdiv_q <= '0;
        end else if (w_tick) begin
            wdiv_q <= wdiv_q + 3'h1;
        end
    end
    // prescaler input is watch clock / 4
    assign w4_tick = w_tick && wdiv_q[1:0] == W4_LAST;

    always_comb begin
        case (ctrl_q.sa)
            SA_DIV2: sa_mask = SA_MASK_DIV2;
            SA_DIV4: sa_mask = SA_MASK_DIV4;
            default: sa_mask = SA_MASK_DIV8;
        endcase
    end
    assign sub_tick = w_tick && &(wdiv_q | sa_mask);

    // watch prescaler ignores power mode while the pin toggles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pres_w_q <= WCH_PRE_RST;
        end else if (tb_clr) begin
            // software clear beats a coincident step
            pres_w_q <= WCH_PRE_RST;
        end else if (w4_tick) begin
            pres_w_q <= pres_w_q + 5'h01;
        end
    end
    // bit k toggles at watch clock / 2^(k+3)
    assign watch_taps = pres_w_q;

    // time-base step, kept alive through standby
    assign time_base_tick = ctrl_q.tb_sel && w4_tick;

    // ==========================================================
    // clock gating per mode
    // cpu stops in both sleep modes
    assign cpu_clk_en = (mode_q == CPM_ACTIVE && sys_tick)
        || (mode_q == CPM_SUBACTIVE && sub_tick);
    assign periph_clk_en = (sys_run && sys_tick) || (sub_run && sub_tick);
    assign module_clk_en = {NUM_MOD{periph_clk_en}} & ~ctrl_q.mstop;

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_s_halt_zero: assert property (
        !sys_run |=> pres_s_q == SYS_PRE_RST)
        else $error("system prescaler not zero outside active/sleep");
    a_s_step_one: assert property (
        sys_tick |=> pres_s_q == $past(pres_s_q) + 13'h0001)
        else $error("system prescaler did not advance by one");
    a_s_hold_idle: assert property (
        (sys_run && !sys_tick) ##1 sys_run |-> $stable(pres_s_q))
        else $error("system prescaler moved without a tick");
    // divide by eight spacing
    // a new select value may legally end the gap early
    a_div8_gap: assert property (
        (sys_tick && ctrl_q.ma == MA_DIV8)
        |=> (!sys_tick || ctrl_q.ma != MA_DIV8)[*7])
        else $error("system clock at /8 ticked early");
    a_w_clear: assert property (
        tb_clr |=> pres_w_q == WCH_PRE_RST)
        else $error("watch prescaler not cleared by time-base write");
    a_w_standby_run: assert property (
        (w4_tick && !tb_clr && mode_q == CPM_STANDBY)
        |=> pres_w_q == $past(pres_w_q) + 5'h01)
        else $error("watch prescaler stalled in standby");
    a_cpu_sleep_off: assert property (
        !(mode_q == CPM_ACTIVE || mode_q == CPM_SUBACTIVE) |-> !cpu_clk_en)
        else $error("cpu clock running in a sleep mode");
    a_standby_quiet: assert property (
        mode_q == CPM_STANDBY |-> !periph_clk_en && module_clk_en == '0)
        else $error("clock running in standby");
    // time-base step matches a watch step
    // judged by the counter, so the gate is not restated here
    a_tb_follow: assert property (
        (time_base_tick && !tb_clr)
        |=> pres_w_q == $past(pres_w_q) + 5'h01)
        else $error("time-base step without a watch prescaler step");
    a_software_standby_select_entry: assert property (
        (mode_q == CPM_ACTIVE && sleep_req && ctrl_q.software_standby_select)
        |=> mode_q == CPM_STANDBY)
        else $error("sleep with standby select did not enter standby");
    a_subsleep_entry: assert property (
        (mode_q == CPM_SUBACTIVE && sleep_req && !ctrl_q.software_standby_select)
        |=> mode_q == CPM_SUBSLEEP)
        else $error("sleep from subactive did not enter subsleep");
    a_subsleep_run: assert property (
        (mode_q == CPM_SUBSLEEP && sub_tick)
        |-> periph_clk_en && !cpu_clk_en)
        else $error("subsleep clock enables wrong");
    a_mod_gate: assert property (
        (module_clk_en & ctrl_q.mstop) == '0)
        else $error("stopped module received a clock");

    // main scenarios reached
    c_standby: cover property (mode_q == CPM_STANDBY && w4_tick);
    c_subactive: cover property (mode_q == CPM_SUBACTIVE && cpu_clk_en);
    c_s_wrap: cover property (sys_tick && &pres_s_q);
    c_w_clear: cover property (tb_clr && pres_w_q != WCH_PRE_RST);

endmodule
`default_nettype wire

// ### verification/cpm_periph_model.sv
`default_nettype none
module cpm_periph_model
    import cpm_pkg::*;
#(
    parameter int WATCH_HALF_NS = 15259
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // enables received by cpu and peripherals
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic time_base_tick,
    input wire logic [NUM_SEL-1:0] periph_tick,
    input wire logic [NUM_MOD-1:0] module_clk_en,
    // watch crystal and pulse tallies
    output logic watch_clk_pin,
    output var int cnt [0:14]
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // watch crystal: free running, unrelated in phase to pclk
    initial begin
        watch_clk_pin = 1'b0;
        forever #(WATCH_HALF_NS) watch_clk_pin = ~watch_clk_pin;
    end

    // ==========================================================
    // each consumer tallies the enables it sees; the bench
    // works on differences, so the tallies never need clearing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            foreach (cnt[i]) cnt[i] <= 0;
        end else begin
            cnt[0] <= cnt[0] + int'(cpu_clk_en);
            cnt[1] <= cnt[1] + int'(periph_clk_en);
            cnt[2] <= cnt[2] + int'(time_base_tick);
            for (int i = 0; i < 4; i++) begin
                cnt[3+i] <= cnt[3+i] + int'(periph_tick[i]);
            end
            for (int i = 0; i < 8; i++) begin
                cnt[7+i] <= cnt[7+i] + int'(module_clk_en[i]);
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/clock_prescalers_power_modes_tb.sv
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module clock_prescalers_power_modes_tb
    import cpm_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // signals
    logic pclk, presetn, psel, penable, pwrite, sleep_req, wake_req;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, er, watch_clk_pin;
    logic cpu_clk_en, periph_clk_en, time_base_tick;
    logic [NUM_MOD-1:0] module_clk_en;
    logic [SYS_PRE_W-1:0] sys_taps, s0;
    logic [WCH_PRE_W-1:0] watch_taps, w0;
    logic [NUM_SEL-1:0] periph_tick;
    logic [2:0] power_mode;
    int cnt [0:14];
    int base [0:14];
    int d [0:14];
    int fails, n_checks;

    // ==========================================================
    // design and consumers
    cpm_clock_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .watch_clk_pin(watch_clk_pin),
        .sleep_req(sleep_req), .wake_req(wake_req),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .module_clk_en(module_clk_en), .time_base_tick(time_base_tick),
        .sys_taps(sys_taps), .watch_taps(watch_taps),
        .periph_tick(periph_tick), .power_mode(power_mode));
    // fast watch crystal keeps the run short
    cpm_periph_model #(.WATCH_HALF_NS(110)) u_peer (.pclk(pclk),
        .presetn(presetn), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .time_base_tick(time_base_tick),
        .periph_tick(periph_tick), .module_clk_en(module_clk_en),
        .watch_clk_pin(watch_clk_pin), .cnt(cnt));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ==========================================================
    // shared tasks
    task summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task give_up();
        fails++;
        $display("[ERR] %0t wait ran out", $time);
        summarize();
    endtask

    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) give_up();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // sleep or wake request, then one edge for the mode to land
    task pulse(input logic slp);
        @(posedge pclk);
        if (slp) sleep_req <= 1'b1;
        else wake_req <= 1'b1;
        @(posedge pclk);
        sleep_req <= 1'b0;
        wake_req <= 1'b0;
        @(posedge pclk);
    endtask

    task mark();
        base = cnt;
    endtask

    task diff();
        foreach (d[i]) d[i] = cnt[i] - base[i];
    endtask

    task span(input int n);
        mark();
        repeat (n) @(posedge pclk);
        diff();
    endtask

    // waits for the next watch prescaler step
    task wstep();
        logic [4:0] w;
        int i;
        w = watch_taps;
        for (i = 0; i < 400; i++) begin
            @(posedge pclk);
            if (watch_taps !== w) break;
        end
        if (i == 400) give_up();
    endtask

    task wait_w(input logic [4:0] v);
        int i;
        for (i = 0; i < 2000 && watch_taps !== v; i++) @(posedge pclk);
        if (i == 2000) give_up();
    endtask

    // ==========================================================
    // scenarios
    task t_count();
        int i;
        s0 = sys_taps;
        repeat (8) begin
            @(posedge pclk);
            `CHK(sys_taps, s0 + 13'h1)
            s0 = sys_taps;
        end
        for (i = 0; i < 9000 && sys_taps !== 13'h1fff; i++) @(posedge pclk);
        if (i == 9000) give_up();
        @(posedge pclk);
        `CHK(sys_taps, 13'h0)
    endtask

    // last entry leaves the oscillator undivided
    task automatic t_div();
        logic [2:0] ma [5] = '{MA_DIV64, MA_DIV32, MA_DIV16, MA_DIV8, MA_OSC};
        int gap [5] = '{64, 32, 16, 8, 1};
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, OFS_SYSCTL2, {25'h0, ma[k], 4'h0});
            repeat (80) @(posedge pclk);
            s0 = sys_taps;
            span(128);
            `CHK(d[1], 128 / gap[k])
            `CHK(d[0], 128 / gap[k])
            `CHK(sys_taps - s0, 13'(128 / gap[k]))
        end
    endtask

    task t_taps();
        apb(1'b1, OFS_TAPSEL, 32'h2310);
        apb(1'b0, OFS_TAPSEL, 32'h0);
        `CHK(rd, 32'h2310)
        repeat (20) @(posedge pclk);
        span(64);
        `CHK(d[3], 32)
        `CHK(d[4], 16)
        `CHK(d[5], 4)
        `CHK(d[6], 8)
    endtask

    task t_mstop();
        apb(1'b1, OFS_MODSTBY, 32'h05);
        // the access edge itself still gates with the old stop bits
        @(posedge pclk);
        span(32);
        `CHK(d[7], 0)
        `CHK(d[8], 32)
        `CHK(d[9], 0)
        apb(1'b1, 8'h18, 32'hff);
        apb(1'b0, 8'h18, 32'h0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b0, OFS_MODSTBY, 32'h0);
        `CHK(rd, 32'h05)
        apb(1'b1, OFS_MODSTBY, 32'h0);
    endtask

    task t_sleep();
        apb(1'b1, OFS_SYSCTL1, 32'h0);
        pulse(1'b1);
        `CHK(power_mode, CPM_SLEEP)
        span(32);
        `CHK(d[0], 0)
        `CHK(d[1], 32)
        pulse(1'b0);
        `CHK(power_mode, CPM_ACTIVE)
    endtask

    task t_standby();
        apb(1'b1, OFS_SYSCTL1, 32'h80);
        apb(1'b1, OFS_TBMODE, 32'h10);
        pulse(1'b1);
        `CHK(power_mode, CPM_STANDBY)
        w0 = watch_taps;
        span(300);
        `CHK(sys_taps, 13'h0)
        `CHK(d[0] + d[1], 0)
        `CHK(d[2], int'(5'(watch_taps - w0)))
        `CHK(watch_taps === w0, 1'b0)
        wait_w(5'h1f);
        wstep();
        `CHK(watch_taps, 5'h0)
        // clear lands on the write's own access edge; allow one later step
        wait_w(5'h10);
        apb(1'b1, OFS_TBMODE, 32'h1c);
        repeat (2) @(posedge pclk);
        `CHK(watch_taps <= 5'h1, 1'b1)
    endtask

    task automatic t_sub();
        int e [3] = '{4, 2, 1};
        apb(1'b1, OFS_SYSCTL2, 32'h08);
        pulse(1'b0);
        `CHK(power_mode, CPM_SUBACTIVE)
        `CHK(sys_taps, 13'h0)
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, OFS_SYSCTL2, 32'h08 | k);
            wstep();
            mark();
            wstep();
            wstep();
            diff();
            `CHK(d[0], e[k])
            `CHK(d[1], e[k])
        end
        apb(1'b1, OFS_SYSCTL1, 32'h0);
        pulse(1'b1);
        `CHK(power_mode, CPM_SUBSLEEP)
        wstep();
        mark();
        wstep();
        wstep();
        diff();
        `CHK(d[0], 0)
        `CHK(d[1], 1)
        pulse(1'b0);
        `CHK(power_mode, CPM_SUBACTIVE)
    endtask

    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        sleep_req = 1'b0;
        wake_req = 1'b0;
        repeat (5) @(posedge pclk);
        `CHK(sys_taps, SYS_PRE_RST)
        `CHK(watch_taps, WCH_PRE_RST)
        presetn <= 1'b1;
        @(posedge pclk);
        t_count();
        t_div();
        t_taps();
        t_mstop();
        t_sleep();
        t_standby();
        t_sub();
        summarize();
    end
endmodule
`default_nettype wire
